// ===== inc/rfw_pkg.sv
package rfw_pkg;
  // ==========================================================
  // Register map
  localparam logic [3:0] ADDR_ALARM_MIN  = 4'hB;
  localparam logic [3:0] ADDR_ALARM_HOUR = 4'hC;
  localparam logic [7:0] MIN_MASK        = 8'h7F;
  localparam logic [7:0] HOUR_MASK       = 8'h3F;
  localparam int         HOUR_PM_BIT     = 5;
  localparam int         MIN_TENS_LSB    = 4;
  // ==========================================================
  // Transfer formats
  localparam logic [3:0] FMT_WR_SINGLE = 4'h8;
  localparam logic [3:0] FMT_WR_BURST  = 4'h0;
  localparam logic [3:0] FMT_RD_SINGLE = 4'hC;
  localparam logic [3:0] FMT_RD_BURST  = 4'h4;
  localparam int         BYTE_BITS     = 8;
  localparam int         FIFO_DEPTH    = 8;
  // ==========================================================
  // Types
  typedef enum logic [1:0] {
    RFW_CMD   = 2'b00,
    RFW_WRITE = 2'b01,
    RFW_READ  = 2'b10,
    RFW_IDLE  = 2'b11
  } rfw_state_t;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] data;
  } rfw_wr_t;

  typedef struct packed {
    logic sclk;
    logic cs;
    logic sdi;
  } rfw_pins_t;
endpackage

// ===== src/rfw_fifo.sv
`timescale 1ns/1ns
module rfw_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // Fill side
  input  wire logic             inValid,
  output wire logic             inReady,
  input  wire logic [WIDTH-1:0] inData,
  // Drain side
  output wire logic             outValid,
  input  wire logic             outReady,
  output wire logic [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wrPtr_r;
  logic [AW-1:0]    rdPtr_r;
  logic [AW:0]      count_r;
  logic             push;
  logic             pop;

  assign inReady  = (count_r != (AW+1)'(DEPTH));
  assign outValid = (count_r != '0);
  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;
  assign outData  = mem[rdPtr_r];

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wrPtr_r] <= inData;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
      count_r <= '0;
    end else begin
      if (push) begin
        wrPtr_r <= wrPtr_r + 1'b1;
      end
      if (pop) begin
        rdPtr_r <= rdPtr_r + 1'b1;
      end
      count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// ===== src/rfw_serial_port.sv
`timescale 1ns/1ns
// Behaviour
// - Alarm hour bit 5 is PM flag in 12h mode, tens bit in 24h.
// - 12h mode: midnight reads 12, noon reads 32.
// - Alarm values indefinite at power-on (reset clears both to zero here); unused upper bits read zero.
// - Clock low at select rise: output on rise, sample on fall.
// - Clock high at select rise: output on fall, sample on rise.
// - Session runs while select high; select low aborts partial byte.
// - All traffic is whole bytes, most significant bit first.
// - Command upper four bits load the address pointer.
// - Command lower four bits store the transfer format.
// - Format 8h writes the next byte at the head address.
// - After single write, next byte is a new command.
// - Format 0h writes every following byte at the pointer.
// - Bursts increment pointer per byte, wrapping Fh to 0h.
// - Bursts continue until select goes low.
// - Format Ch shifts the head address byte out.
// - After single read, a further command byte is accepted.
// - Format 4h shifts successive bytes out from head address.
// - Minute register: bits 6-4 tens, 3-0 units, bit 7 zero.
module rfw_serial_port
  import rfw_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // Serial pins
  input  wire logic       chipSelect,
  input  wire logic       serialClock,
  input  wire logic       serialIn,
  output wire logic       serialOut,
  output wire logic       serialOutOe_n,
  // Alarm values for the compare logic
  output wire logic [6:0] alarmMinute,
  output wire logic [5:0] alarmHour,
  output wire logic       alarmPmFlag,
  // Write-queue status
  output wire logic       wrQueueFull
);
  import rfw_pkg::*;

  // ==========================================================
  // Pin synchronisers
  rfw_pins_t pinsMeta_r;
  rfw_pins_t pins_r;
  logic      sclkPrev_r;
  logic      csPrev_r;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pinsMeta_r <= '0;
      pins_r     <= '0;
      sclkPrev_r <= 1'b0;
      csPrev_r   <= 1'b0;
    end else begin
      pinsMeta_r <= '{sclk: serialClock, cs: chipSelect, sdi: serialIn};
      pins_r     <= pinsMeta_r;
      sclkPrev_r <= pins_r.sclk;
      csPrev_r   <= pins_r.cs;
    end
  end

  logic csRise;
  logic sclkRise;
  logic sclkFall;
  assign csRise   = pins_r.cs && !csPrev_r;
  assign sclkRise = pins_r.sclk && !sclkPrev_r;
  assign sclkFall = !pins_r.sclk && sclkPrev_r;

  // ==========================================================
  // Edge mode, latched at each session start
  logic polHigh_r;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      polHigh_r <= 1'b0;
    end else if (csRise) begin
      polHigh_r <= pins_r.sclk;
    end
  end

  logic sampleEdge;
  logic shiftEdge;
  logic active;
  assign active     = pins_r.cs && !csRise;
  assign sampleEdge = active && (polHigh_r ? sclkRise : sclkFall);
  assign shiftEdge  = active && (polHigh_r ? sclkFall : sclkRise);

  // ==========================================================
  // Receive shifter
  logic [2:0] bitCnt_r;
  logic [6:0] rxShift_r;
  logic       byteDone;
  logic [7:0] rxByte;
  assign byteDone = sampleEdge && (bitCnt_r == 3'h7);
  assign rxByte   = {rxShift_r, pins_r.sdi};

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bitCnt_r  <= '0;
      rxShift_r <= '0;
    end else if (!pins_r.cs || csRise) begin
      bitCnt_r  <= '0;
    end else if (sampleEdge) begin
      bitCnt_r  <= bitCnt_r + 3'h1;
      rxShift_r <= rxByte[6:0];
    end
  end

  // ==========================================================
  // Command decode and pointer
  rfw_state_t state_r;
  rfw_state_t state_nxt;
  logic [3:0] addrPtr_r;
  logic [3:0] format_r;
  logic       burst;
  assign burst = (format_r == FMT_WR_BURST) || (format_r == FMT_RD_BURST);

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      RFW_CMD: begin
        if (byteDone) begin
          case (rxByte[3:0])
            FMT_WR_SINGLE,
            FMT_WR_BURST:  state_nxt = RFW_WRITE;
            FMT_RD_SINGLE,
            FMT_RD_BURST:  state_nxt = RFW_READ;
            default:       state_nxt = RFW_IDLE;
          endcase
        end
      end
      RFW_WRITE,
      RFW_READ: begin
        if (byteDone && !burst) begin
          state_nxt = RFW_CMD;
        end
      end
      RFW_IDLE: state_nxt = RFW_IDLE;
      default:  state_nxt = RFW_CMD;
    endcase
    if (!pins_r.cs || csRise) begin
      state_nxt = RFW_CMD;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r <= RFW_CMD;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      addrPtr_r <= '0;
      format_r  <= '0;
    end else if (byteDone && state_r == RFW_CMD) begin
      addrPtr_r <= rxByte[7:4];
      format_r  <= rxByte[3:0];
    end else if (byteDone && burst &&
                 (state_r == RFW_WRITE || state_r == RFW_READ)) begin
      addrPtr_r <= addrPtr_r + 4'h1;
    end
  end

  // ==========================================================
  // Write queue into the register file
  rfw_wr_t wrIn;
  rfw_wr_t wrOut;
  logic    wrValid;
  logic    wrReady;
  logic    qValid;
  assign wrIn    = '{addr: addrPtr_r, data: rxByte};
  assign wrValid = byteDone && (state_r == RFW_WRITE);

  rfw_fifo #(
    .WIDTH ($bits(rfw_wr_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_wr_fifo (
    .clk      (clk),
    .rst      (rst),
    .inValid  (wrValid),
    .inReady  (wrReady),
    .inData   (wrIn),
    .outValid (qValid),
    .outReady (1'b1),
    .outData  (wrOut)
  );
  // Drains one per cycle; a byte takes many cycles, so it never fills
  assign wrQueueFull = !wrReady;

  // ==========================================================
  // Alarm registers
  logic [7:0] alarmMin_r;
  logic [7:0] alarmHour_r;

  // Power-on contents are indefinite by nature; cleared here to be defined
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      alarmMin_r  <= '0;
      alarmHour_r <= '0;
    end else if (qValid) begin
      if (wrOut.addr == ADDR_ALARM_MIN) begin
        alarmMin_r  <= wrOut.data & MIN_MASK;
      end
      if (wrOut.addr == ADDR_ALARM_HOUR) begin
        alarmHour_r <= wrOut.data & HOUR_MASK;
      end
    end
  end

  // Hour stored raw, so 12 and 32 encodings pass unchanged
  assign alarmHour   = alarmHour_r[5:0];
  assign alarmPmFlag = alarmHour_r[HOUR_PM_BIT];
  assign alarmMinute = alarmMin_r[6:0];

  function automatic logic [7:0] readReg(input logic [3:0] a);
    case (a)
      ADDR_ALARM_MIN:  readReg = alarmMin_r & MIN_MASK;
      ADDR_ALARM_HOUR: readReg = alarmHour_r & HOUR_MASK;
      default:         readReg = 8'h00;
    endcase
  endfunction

  // ==========================================================
  // Transmit shifter
  logic [7:0] txShift_r;
  logic       txOn_r;
  logic       loadTx;
  logic [3:0] loadAddr;
  assign loadAddr = (state_r == RFW_CMD) ? rxByte[7:4] : addrPtr_r + 4'h1;
  assign loadTx   = byteDone &&
                    ((state_r == RFW_CMD &&
                      (rxByte[3:0] == FMT_RD_SINGLE ||
                       rxByte[3:0] == FMT_RD_BURST)) ||
                     (state_r == RFW_READ && format_r == FMT_RD_BURST));

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      txShift_r <= '0;
      txOn_r    <= 1'b0;
    end else if (!pins_r.cs || csRise) begin
      txOn_r    <= 1'b0;
    end else if (loadTx) begin
      txShift_r <= readReg(loadAddr);
      txOn_r    <= 1'b0;
    end else if (state_r == RFW_READ && shiftEdge) begin
      // First shift edge presents the MSB, later edges advance
      if (txOn_r) begin
        txShift_r <= {txShift_r[6:0], 1'b0};
      end
      txOn_r <= 1'b1;
    end else if (state_r != RFW_READ) begin
      txOn_r <= 1'b0;
    end
  end

  assign serialOut     = txOn_r ? txShift_r[7] : 1'b0;
  assign serialOutOe_n = !txOn_r;
endmodule

// ===== sim/rfw_host_model.sv
`timescale 1ns/1ns
module rfw_host_model (
  // Clock
  input  wire logic clk,
  // Serial pins
  output logic      chipSelect,
  output logic      serialClock,
  output logic      serialIn,
  input  wire logic serialOut
);
  initial begin
    chipSelect = 1'b0;
    serialClock = 1'b0;
    serialIn = 1'b0;
  end
  task automatic waitClk(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Idle level at select rise picks the edge pairing
  task automatic start(input logic pol);
    serialClock <= pol;
    waitClk(6);
    chipSelect <= 1'b1;
    waitClk(6);
  endtask
  // MSB first; shift edge, then sample edge 7 clk later
  task automatic xfer(input logic [7:0] tx, input int n,
                      output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - n; i--) begin
      serialClock <= ~serialClock;
      serialIn <= tx[i];
      waitClk(7);
      rx[i] = serialOut;
      serialClock <= ~serialClock;
      waitClk(6);
    end
  endtask
  // Only select low ends a burst
  task automatic stop();
    waitClk(6);
    chipSelect <= 1'b0;
    serialIn <= ~serialIn;
    waitClk(8);
  endtask
endmodule

// ===== sim/rfw_serial_port_assertions.sv
`timescale 1ns/1ns
module rfw_serial_port_assertions (
  // Clock and reset
  input wire logic       clk,
  input wire logic       rst,
  // Pins
  input wire logic       chipSelect,
  input wire logic       serialClock,
  input wire logic       serialIn,
  input wire logic       serialOut,
  input wire logic       serialOutOe_n,
  // Alarm values
  input wire logic [6:0] alarmMinute,
  input wire logic [5:0] alarmHour,
  input wire logic       alarmPmFlag,
  input wire logic       wrQueueFull
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // ==========
  // Age of the last host clock edge
  logic       sclkPrev_r;
  logic [3:0] sclkAge_r;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sclkPrev_r <= 1'b0;
      sclkAge_r <= 4'h0;
    end else begin
      sclkPrev_r <= serialClock;
      if (serialClock != sclkPrev_r) sclkAge_r <= 4'h0;
      else if (sclkAge_r != 4'hF) sclkAge_r <= sclkAge_r + 4'h1;
    end
  end
  // ==========
  // Properties
  sequence s_quiet; !chipSelect [*5]; endsequence
  // Hour and its PM flag move together, and only inside a session
  property p_pm;
    $changed({alarmPmFlag, alarmHour}) |->
      chipSelect && alarmPmFlag == alarmHour[5];
  endproperty
  property p_idle; serialOutOe_n |-> !serialOut; endproperty
  property p_off; s_quiet |-> serialOutOe_n; endproperty
  property p_hold; s_quiet |=> $stable({alarmMinute, alarmHour}); endproperty
  // Inside a session, output may only move shortly after a host clock edge
  property p_edge;
    chipSelect && $changed({serialOut, serialOutOe_n}) |-> sclkAge_r <= 4'h4;
  endproperty
  property p_sess; !serialOutOe_n |-> chipSelect || $past(chipSelect, 7);
  endproperty
  property p_first; $fell(serialOutOe_n) |-> $past(chipSelect, 8);
  endproperty
  property p_room; !wrQueueFull; endproperty
  a_pm: assert property (p_pm) else $error("pm flag");
  a_idle: assert property (p_idle) else $error("idle out");
  a_off: assert property (p_off) else $error("drive off");
  a_hold: assert property (p_hold) else $error("reg moved");
  a_edge: assert property (p_edge) else $error("edge");
  a_sess: assert property (p_sess) else $error("no session");
  a_first: assert property (p_first) else $error("early");
  a_room: assert property (p_room) else $error("queue");
endmodule
bind rfw_serial_port rfw_serial_port_assertions i_rfw_serial_port_assertions (
  .clk(clk), .rst(rst), .chipSelect(chipSelect), .serialClock(serialClock),
  .serialIn(serialIn), .serialOut(serialOut), .serialOutOe_n(serialOutOe_n),
  .alarmMinute(alarmMinute), .alarmHour(alarmHour),
  .alarmPmFlag(alarmPmFlag), .wrQueueFull(wrQueueFull));

// ===== sim/rfw_serial_port_tb.sv
`timescale 1ns/1ns
module rfw_serial_port_tb;
  import rfw_pkg::*;
  typedef struct packed {
    logic       pol;
    logic [3:0] addr;
    logic [7:0] data;
    logic [7:0] want;
  } rfw_row_t;
  // Rows mix real alarm times with set upper bits and an unmapped address
  localparam rfw_row_t ROWS [5] = '{'{1'b0, 4'hB, 8'h59, 8'h59},
    '{1'b1, 4'hC, 8'h32, 8'h32}, '{1'b0, 4'hC, 8'hD2, 8'h12},
    '{1'b1, 4'hB, 8'hC5, 8'h45}, '{1'b0, 4'h5, 8'hA5, 8'h00}};
  localparam logic [7:0] BURST [3] = '{8'h31, 8'h01, 8'h00};
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic       sdoLine = 1'b0;
  logic       chipSelect, serialClock, serialIn, serialOut, serialOutOe_n;
  logic       alarmPmFlag, wrQueueFull;
  logic [6:0] alarmMinute;
  logic [5:0] alarmHour;
  logic [7:0] rx;
  int         errTotal, checksDone, cycles;
  initial forever #5 clk = ~clk;
  // Released output line toggles so a stale bit never reads as data
  always @(posedge clk) sdoLine <= serialOutOe_n ? ~sdoLine : serialOut;
  rfw_serial_port i_rfw_serial_port (.clk(clk), .rst(rst),
    .chipSelect(chipSelect), .serialClock(serialClock), .serialIn(serialIn),
    .serialOut(serialOut), .serialOutOe_n(serialOutOe_n),
    .alarmMinute(alarmMinute), .alarmHour(alarmHour),
    .alarmPmFlag(alarmPmFlag), .wrQueueFull(wrQueueFull));
  rfw_host_model i_rfw_host_model (.clk(clk), .chipSelect(chipSelect),
    .serialClock(serialClock), .serialIn(serialIn), .serialOut(sdoLine));
  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    checksDone++;
    if (seen !== want) begin
      errTotal++;
      $display("Error %0t: saw %h want %h", $time, seen, want);
    end
  endtask
  task automatic results();
    $display("Checks %0d, errors %0d", checksDone, errTotal);
    if (errTotal == 0 && checksDone > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic rd(input logic [3:0] a);
    i_rfw_host_model.start(1'b0);
    i_rfw_host_model.xfer({a, FMT_RD_SINGLE}, 8, rx);
    i_rfw_host_model.xfer(8'h00, 8, rx);
    i_rfw_host_model.stop();
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      errTotal++;
      results();
    end
  end
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    // ==========
    // Table: single write, then two single reads, one session
    for (int i = 0; i < 5; i++) begin
      i_rfw_host_model.start(ROWS[i].pol);
      i_rfw_host_model.xfer({ROWS[i].addr, FMT_WR_SINGLE}, 8, rx);
      i_rfw_host_model.xfer(ROWS[i].data, 8, rx);
      for (int k = 0; k < 2; k++) begin
        i_rfw_host_model.xfer({ROWS[i].addr, FMT_RD_SINGLE}, 8, rx);
        i_rfw_host_model.xfer(8'h00, 8, rx);
        check(rx, ROWS[i].want);
      end
      i_rfw_host_model.stop();
      check({6'h00, wrQueueFull, serialOutOe_n}, 8'h01);
      if (ROWS[i].addr == ADDR_ALARM_MIN)
        check({1'b0, alarmMinute}, ROWS[i].want);
      if (ROWS[i].addr == ADDR_ALARM_HOUR)
        check({1'b0, alarmPmFlag, alarmHour}, {1'b0, ROWS[i].want[5],
              ROWS[i].want[5:0]});
    end
    // ==========
    // Burst write round the whole map, then burst read
    i_rfw_host_model.start(1'b1);
    i_rfw_host_model.xfer({ADDR_ALARM_HOUR, FMT_WR_BURST}, 8, rx);
    for (int i = 0; i < 16; i++)
      i_rfw_host_model.xfer({2'b00, i[1:0], 4'h1}, 8, rx);
    i_rfw_host_model.stop();
    i_rfw_host_model.start(1'b0);
    i_rfw_host_model.xfer({ADDR_ALARM_MIN, FMT_RD_BURST}, 8, rx);
    for (int j = 0; j < 3; j++) begin
      i_rfw_host_model.xfer(8'h00, 8, rx);
      check(rx, BURST[j]);
    end
    i_rfw_host_model.stop();
    // ==========
    // Aborted byte, then an undefined format
    i_rfw_host_model.start(1'b0);
    i_rfw_host_model.xfer({ADDR_ALARM_MIN, FMT_WR_SINGLE}, 8, rx);
    i_rfw_host_model.xfer(8'h00, 4, rx);
    i_rfw_host_model.stop();
    i_rfw_host_model.start(1'b1);
    i_rfw_host_model.xfer({ADDR_ALARM_MIN, 4'h2}, 8, rx);
    i_rfw_host_model.xfer(8'h00, 8, rx);
    i_rfw_host_model.stop();
    rd(ADDR_ALARM_MIN);
    check(rx, 8'h31);
    // ==========
    // Reset in mid-run
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    check({1'b0, alarmMinute}, 8'h00);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    rd(ADDR_ALARM_HOUR);
    check(rx, 8'h00);
    results();
  end
endmodule
